// [hw/periodic_wakeup_counter.sv]
/*
 periodic wakeup counter: source select, prescaler, 8-bit counter with
 modulo match, match flag, interrupt and converter trigger, apb slave.
 assumes clock source inputs are synchronous levels sampled on core_clk.
*/
// Chosen here: the APB register port and the address map.
// Contract
// (R1) one 8-bit up-counter on prescaler ticks, compared with match_limit.
// (R2) every match pulses the converter trigger, regardless of irq enable.
// (R3) deepest stop lets only low-power and external sources clock counting.
// (R4) counter registers keep contents over a deep-stop wakeup.
// (R5) bus gate bit resets enabled; cleared, it cuts register access.
// (R6) counting continues through wait; enabled match interrupt wakes cpu.
// (R7) counting continues in both stop modes; enabled interrupt wakes system.
// (R8) debug halt freezes prescaler and counter; resumes from held value.
// (R9) flag bit 7 sets on match; write 1 clears; reset clears.
// (R10) source select 6:5: 00 low-power, 01 external, 1x internal.
// (R11) changing source select clears prescaler and counter.
// (R12) enable bit 4 gates match flag onto interrupt; reset clears it.
// (R13) divider select 3:0 resets 0000; a changed value clears counters.
// (R14) source bit 0 low: codes map off,8,32,...,1000.
// (R15) source bit 0 high: codes map off,1024..65536,1000..200000.
// (R16) match returns counter to zero, sets flag; limit zero matches each tick.
// (R17) any match_limit write clears prescaler and counter; resets to zero.
// (R18) current_count is read-only; cleared on reset, limit write, changes.
// (R19) match events and register writes cross into counting safely.
`timescale 1ns/10ps
module periodic_wakeup_counter
    import wakeup_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic lpo_clk_in,
    input wire logic ext_clk_in,
    input wire logic int_clk_in,
    input wire logic deep_stop,
    input wire logic debug_halt,
    output logic irq,
    output logic conv_trigger
);

    logic pready_ff;
    logic pslverr_ff;
    logic [DATA_W-1:0] prdata_ff;
    logic irq_ff;
    logic conv_trigger_ff;

    // answer states of the register bus
    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_ANSWER,
        BUS_RELEASE
    } bus_e;

    logic match_flag_ff;
    logic [1:0] source_select_ff;
    logic match_irq_enable_ff;
    logic [3:0] divider_select_ff;
    logic [CNT_W-1:0] match_limit_ff;
    logic [CNT_W-1:0] counter_value_ff;
    logic irq_status_ff;
    logic irq_mask_ff;
    logic bus_gate_ff;
    bus_e bus_state_ff;
    bus_e nxt_bus_state;

    logic first_acc;
    logic done;
    logic wr;
    logic rd;
    logic sc_wr;
    logic lim_wr;
    logic ist_rd;
    logic mask_wr;
    logic gate_wr;
    logic [1:0] new_src;
    logic [3:0] new_ps;
    logic clear_cnt;
    logic [2:0] src_lvl;
    logic [2:0] src_rise;
    logic src_edge;
    logic run;
    logic tick;
    logic match;
    logic [DATA_W-1:0] rd_data;
    logic rd_err;
    logic [CNT_W-1:0] sc_value;

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign irq = irq_ff;
    assign conv_trigger = conv_trigger_ff;

    // one wait state: answer prepared in the first access cycle
    assign first_acc = psel && penable && bus_state_ff == BUS_IDLE;
    assign done = psel && penable && pready_ff;
    assign wr = done && pwrite;
    assign rd = done && !pwrite;

    // gated bus clock: block registers are unreachable, counting goes on
    assign sc_wr = wr && bus_gate_ff && paddr == OFS_STATUS_CONTROL; // [R5]
    assign lim_wr = wr && bus_gate_ff && paddr == OFS_MATCH_LIMIT; // [R5]
    assign ist_rd = rd && bus_gate_ff && paddr == OFS_IRQ_STATUS;
    assign mask_wr = wr && bus_gate_ff && paddr == OFS_IRQ_MASK;
    assign gate_wr = wr && paddr == OFS_BUS_GATE;

    assign new_src = pwdata[SRC_HI:SRC_LO];
    assign new_ps = pwdata[PS_HI:PS_LO];

    // writes act in this same domain, so counting sees them at once [R19]
    assign clear_cnt = lim_wr // [R17]
        || (sc_wr && new_src != source_select_ff) // [R11]
        || (sc_wr && new_ps != divider_select_ff); // [R13]

    assign sc_value = {match_flag_ff, source_select_ff, match_irq_enable_ff,
        divider_select_ff};

    always_comb begin
        rd_data = DATA_ZERO;
        rd_err = 1'b0;
        case (paddr)
            OFS_STATUS_CONTROL: begin
                if (bus_gate_ff) begin
                    rd_data[CNT_W-1:0] = sc_value;
                end
            end
            OFS_CURRENT_COUNT: begin
                if (bus_gate_ff) begin
                    rd_data[CNT_W-1:0] = counter_value_ff; // [R18]
                end
            end
            OFS_MATCH_LIMIT: begin
                if (bus_gate_ff) begin
                    rd_data[CNT_W-1:0] = match_limit_ff;
                end
            end
            OFS_IRQ_STATUS: begin
                if (bus_gate_ff) begin
                    rd_data[IRQ_MATCH_BIT] = irq_status_ff;
                end
            end
            OFS_IRQ_MASK: begin
                if (bus_gate_ff) begin
                    rd_data[IRQ_MATCH_BIT] = irq_mask_ff;
                end
            end
            OFS_BUS_GATE: begin
                rd_data[GATE_BIT] = bus_gate_ff;
            end
            default: begin
                rd_err = 1'b1;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= DATA_ZERO;
        end else if (ce) begin
            pready_ff <= first_acc;
            if (first_acc) begin
                pslverr_ff <= rd_err;
                prdata_ff <= pwrite ? DATA_ZERO : rd_data;
            end else begin
                pslverr_ff <= 1'b0;
            end
        end
    end

    // one answer per access phase, even if a master keeps penable high
    always_comb begin
        nxt_bus_state = bus_state_ff;
        case (bus_state_ff)
            BUS_IDLE: begin
                if (psel && penable) begin
                    nxt_bus_state = BUS_ANSWER;
                end
            end
            BUS_ANSWER: begin
                nxt_bus_state = BUS_RELEASE;
            end
            BUS_RELEASE: begin
                if (!(psel && penable)) begin
                    nxt_bus_state = BUS_IDLE;
                end
            end
            default: begin
                nxt_bus_state = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            bus_state_ff <= BUS_IDLE;
        end else if (ce) begin
            bus_state_ff <= nxt_bus_state;
        end
    end

    // bus gate defaults enabled after every reset
    always_ff @(posedge core_clk) begin
        if (rst) begin
            bus_gate_ff <= GATE_RESET; // [R5]
        end else if (ce && gate_wr) begin
            bus_gate_ff <= pwdata[GATE_BIT]; // [R5]
        end
    end

    // control fields; mode entry and wakeup leave them alone [R4]
    always_ff @(posedge core_clk) begin
        if (rst) begin
            source_select_ff <= SRC_RESET; // [R10]
            match_irq_enable_ff <= 1'b0; // [R12]
            divider_select_ff <= PS_RESET; // [R13]
        end else if (ce && sc_wr) begin
            source_select_ff <= new_src; // [R10]
            match_irq_enable_ff <= pwdata[IE_BIT]; // [R12]
            divider_select_ff <= new_ps; // [R13]
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            match_limit_ff <= LIMIT_RESET; // [R17]
        end else if (ce && lim_wr) begin
            match_limit_ff <= pwdata[CNT_W-1:0];
        end
    end

    assign src_lvl = {int_clk_in, ext_clk_in, lpo_clk_in};

    // one detector per source, so a source switch never fakes an edge
    for (genvar i = 0; i < $bits(src_lvl); i++) begin : g_src_edge
        logic prev_ff;
        always_ff @(posedge core_clk) begin
            if (rst) begin
                prev_ff <= 1'b0;
            end else if (ce) begin
                prev_ff <= src_lvl[i];
            end
        end
        assign src_rise[i] = src_lvl[i] && !prev_ff;
    end

    // internal reference is not available in the deepest stop
    always_comb begin
        case (source_select_ff)
            SRC_LPO: src_edge = src_rise[SRC_LPO]; // [R10]
            SRC_EXT: src_edge = src_rise[SRC_EXT]; // [R10]
            default: begin
                src_edge = src_rise[$high(src_rise)] && !deep_stop; // [R3]
            end
        endcase
    end

    // wait and stop modes do not gate run, only debug halt does; deep stop masks the internal source edges
    assign run = !debug_halt; // [R6] [R7] [R8]

    wakeup_prescaler u_prescaler (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .clr(clear_cnt),
        .run(run),
        .src_edge(src_edge),
        .div_code({source_select_ff[0], divider_select_ff}), // [R14] [R15]
        .tick_ff(tick)
    );

    // a tick already in flight when halt begins is dropped, not held
    assign match = tick && run && counter_value_ff == match_limit_ff; // [R1]

    always_ff @(posedge core_clk) begin
        if (rst) begin
            counter_value_ff <= COUNT_RESET; // [R18]
        end else if (ce) begin
            if (clear_cnt) begin
                counter_value_ff <= COUNT_RESET; // [R18]
            end else if (match) begin
                counter_value_ff <= COUNT_RESET; // [R16]
            end else if (tick && run) begin
                counter_value_ff <= counter_value_ff + COUNT_ONE; // [R1]
            end
        end
    end

    // set wins over a same-cycle clear, so no match is lost
    always_ff @(posedge core_clk) begin
        if (rst) begin
            match_flag_ff <= 1'b0; // [R9]
        end else if (ce) begin
            if (match) begin
                match_flag_ff <= 1'b1; // [R9] [R16] [R19]
            end else if (sc_wr && pwdata[FLAG_BIT]) begin
                match_flag_ff <= 1'b0; // [R9]
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            conv_trigger_ff <= 1'b0;
        end else if (ce) begin
            conv_trigger_ff <= match; // [R2]
        end
    end

    // sticky event copy, cleared by reading it
    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_status_ff <= 1'b0;
        end else if (ce) begin
            if (match) begin
                irq_status_ff <= 1'b1;
            end else if (ist_rd) begin
                irq_status_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_mask_ff <= 1'b0;
        end else if (ce && mask_wr) begin
            irq_mask_ff <= pwdata[IRQ_MATCH_BIT];
        end
    end

    // lags the flags by one cycle to keep the output a flop
    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_ff <= 1'b0;
        end else if (ce) begin
            irq_ff <= (match_flag_ff && match_irq_enable_ff) // [R12] [R6] [R7]
                || (irq_status_ff && irq_mask_ff);
        end
    end

endmodule // periodic_wakeup_counter

// [hw/wakeup_pkg.sv]
/*
 periodic wakeup counter: register map, field layout, reset values and the
 divider table.
 assumes a 32-bit apb master and byte addresses on paddr.
*/
package wakeup_pkg;

    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int CNT_W = 8;
    localparam int DIV_W = 18;
    localparam int CODE_W = 5;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_STATUS_CONTROL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CURRENT_COUNT = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_MATCH_LIMIT = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_BUS_GATE = 8'h14;

    // status_control field positions
    localparam int FLAG_BIT = 7;
    localparam int SRC_HI = 6;
    localparam int SRC_LO = 5;
    localparam int IE_BIT = 4;
    localparam int PS_HI = 3;
    localparam int PS_LO = 0;

    // irq_status / irq_mask layout
    localparam int IRQ_MATCH_BIT = 0;
    localparam int GATE_BIT = 0;

    // source_select encodings, 1x is the internal reference
    localparam logic [1:0] SRC_LPO = 2'h0;
    localparam logic [1:0] SRC_EXT = 2'h1;

    // reset values
    localparam logic [1:0] SRC_RESET = 2'h0;
    localparam logic [3:0] PS_RESET = 4'h0;
    localparam logic [CNT_W-1:0] LIMIT_RESET = 8'h00;
    localparam logic [CNT_W-1:0] COUNT_RESET = 8'h00;
    localparam logic [CNT_W-1:0] COUNT_ONE = 8'h01;
    localparam logic GATE_RESET = 1'b1;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

    localparam logic [DIV_W-1:0] DIV_OFF = 18'h0;
    localparam logic [DIV_W-1:0] DIV_ONE = 18'h1;

    // index is {source_select[0], divider_select}
    localparam logic [DIV_W-1:0] DIV_TABLE [32] = '{
        18'h0, 18'h8, 18'h20, 18'h40, 18'h80, 18'h100, 18'h200, 18'h400,
        18'h1, 18'h2, 18'h4, 18'ha, 18'h10, 18'h64, 18'h1f4, 18'h3e8,
        18'h0, 18'h400, 18'h800, 18'h1000, 18'h2000, 18'h4000, 18'h8000,
        18'h10000, 18'h3e8, 18'h7d0, 18'h1388, 18'h2710, 18'h4e20,
        18'hc350, 18'h186a0, 18'h30d40
    };

endpackage

// [hw/wakeup_prescaler.sv]
/*
 prescaler: counts rising edges of the selected source and emits one tick
 per divide-by period.
 assumes src_edge is a one-cycle pulse in the core_clk domain.
*/
`timescale 1ns/10ps
module wakeup_prescaler
    import wakeup_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic clr,
    input wire logic run,
    input wire logic src_edge,
    input wire logic [CODE_W-1:0] div_code,
    output logic tick_ff
);

    logic [DIV_W-1:0] div;
    logic [DIV_W-1:0] count_ff;
    logic at_end;

    assign div = DIV_TABLE[div_code];
    assign at_end = (count_ff == div - DIV_ONE);

    // code zero keeps the prescaler off
    always_ff @(posedge core_clk) begin
        if (rst) begin
            count_ff <= DIV_OFF;
        end else if (ce) begin
            if (clr) begin
                count_ff <= DIV_OFF;
            end else if (run && src_edge && div != DIV_OFF) begin
                if (at_end) begin
                    count_ff <= DIV_OFF;
                end else begin
                    count_ff <= count_ff + DIV_ONE;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            tick_ff <= 1'b0;
        end else if (ce) begin
            tick_ff <= !clr && run && src_edge && div != DIV_OFF && at_end;
        end
    end

endmodule // wakeup_prescaler

// [sim/wakeup_assertions.sv]
/*
 checker for the periodic wakeup counter: bus timing, trigger and irq.
 assumes one core_clk domain; bound from the testbench top file.
*/
`timescale 1ns/10ps
module wakeup_assertions
    import wakeup_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic lpo_clk_in,
    input wire logic ext_clk_in,
    input wire logic int_clk_in,
    input wire logic debug_halt,
    input wire logic irq,
    input wire logic conv_trigger
);
    logic [2:0] src_prev_ff;
    logic src_rose;
    always_ff @(posedge core_clk) begin
        src_prev_ff <= {lpo_clk_in, ext_clk_in, int_clk_in};
    end
    assign src_rose = |({lpo_clk_in, ext_clk_in, int_clk_in} & ~src_prev_ff);
    // ce low freezes everything, so timing relations do not apply then
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (rst || !ce);
    sequence apb_setup;
        psel && !penable;
    endsequence
    sequence apb_one_wait;
        penable && !pready ##1 penable && pready;
    endsequence
    chk_apb_wait_state: assert property (apb_setup |=> apb_one_wait)
        else $error("access phase length wrong");
    chk_err_unmapped: assert property (psel && penable && pready
        |-> pslverr == (paddr > OFS_BUS_GATE))
        else $error("error response wrong");
    chk_trig_pulse: assert property (conv_trigger |=> !conv_trigger)
        else $error("trigger longer than one cycle");
    chk_trig_cause: assert property (conv_trigger |-> $past(src_rose, 2))
        else $error("trigger without source edge");
    chk_irq_rise: assert property ($rose(irq)
        |-> $past(conv_trigger) || $past(pready && pwrite, 2))
        else $error("irq rose without cause");
    chk_irq_fall: assert property ($fell(irq) |-> $past(pready, 2))
        else $error("irq fell without access");
    chk_halt_freeze: assert property (debug_halt [*3] |-> !conv_trigger)
        else $error("match while halted");
    chk_reset_quiet: assert property (@(posedge core_clk) disable iff (!ce)
        rst |=> !irq && !conv_trigger && !pready)
        else $error("outputs active after reset");
endmodule // wakeup_assertions

// [sim/testbench.sv]
/*
 self-checking bench for the periodic wakeup counter, apb register access.
 assumes sources are slow levels driven on core_clk edges.
*/
`timescale 1ns/10ps
module testbench;
    import wakeup_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 8'h00;
    logic [DATA_W-1:0] pwdata = 32'h0;
    logic [DATA_W-1:0] prdata;
    logic pready, pslverr, irq, conv_trigger;
    logic [2:0] src = 3'h0;
    logic deep_stop = 1'b0;
    logic debug_halt = 1'b0;
    logic [DATA_W:0] exp_q[$];
    int fails = 0, total_checks = 0, trig_cnt = 0, cyc = 0, k, t0;
    int divs[3] = '{2, 4, 16};
    int codes[3] = '{9, 10, 12};
    always #50 core_clk = ~core_clk;
    periodic_wakeup_counter periodic_wakeup_counter_i (.core_clk(core_clk),
        .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lpo_clk_in(src[0]), .ext_clk_in(src[1]),
        .int_clk_in(src[2]), .deep_stop(deep_stop), .debug_halt(debug_halt),
        .irq(irq), .conv_trigger(conv_trigger));
    task automatic check(input logic ok, input string what);
        total_checks++;
        if (ok !== 1'b1) begin
            fails++;
            $display("ERROR %0t %s", $time, what);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input int d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input int d);
        apb(1'b1, a, d);
    endtask
    // expectation noted before the access; the monitor pairs it with prdata
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back({a > OFS_BUS_GATE, e});
        apb(1'b0, a, 0);
    endtask
    // edges at least three cycles apart, sources must stay below clk/2
    task automatic edges(input int which, input int n);
        repeat (n) begin
            @(posedge core_clk);
            src[which] <= 1'b1;
            @(posedge core_clk);
            src[which] <= 1'b0;
            repeat ($urandom_range(3, 1)) @(posedge core_clk);
        end
    endtask
    task automatic irq_is(input logic v);
        repeat (3) @(posedge core_clk);
        check(irq === v, "irq level");
    endtask
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (conv_trigger === 1'b1) begin
            trig_cnt <= trig_cnt + 1;
        end
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (exp_q.size() == 0) begin
                check(1'b0, "read without expectation");
            end else begin
                check({pslverr, prdata} === exp_q.pop_front(), "read data");
            end
        end
        if (cyc == 30000) begin
            check(1'b0, "timeout");
            final_report();
        end
    end
    initial begin
        void'($urandom(32'h302f));
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        foreach (codes[i]) rd(OFS_STATUS_CONTROL + 8'(4 * i), 0);
        rd(OFS_IRQ_STATUS, 0);
        rd(OFS_BUS_GATE, 1);
        $display("reset values done");
        wr(OFS_MATCH_LIMIT, 3);
        wr(OFS_STATUS_CONTROL, 32'h18);
        edges(0, 2);
        wr(OFS_CURRENT_COUNT, 32'hff);
        rd(OFS_CURRENT_COUNT, 2);
        edges(0, 2);
        rd(OFS_CURRENT_COUNT, 0);
        rd(OFS_STATUS_CONTROL, 32'h98);
        irq_is(1'b1);
        check(trig_cnt === 1, "trigger count");
        wr(OFS_STATUS_CONTROL, 32'h98);
        rd(OFS_STATUS_CONTROL, 32'h18);
        irq_is(1'b0);
        $display("match done");
        foreach (codes[i]) begin
            wr(OFS_STATUS_CONTROL, codes[i]);
            wr(OFS_MATCH_LIMIT, 32'hff);
            k = $urandom_range(3, 1);
            edges(0, divs[i] * k);
            rd(OFS_CURRENT_COUNT, k);
        end
        wr(OFS_STATUS_CONTROL, 32'h08);
        rd(OFS_CURRENT_COUNT, 0);
        edges(0, 2);
        wr(OFS_STATUS_CONTROL, 32'h28);
        rd(OFS_CURRENT_COUNT, 0);
        wr(OFS_STATUS_CONTROL, 32'h21);
        rd(OFS_CURRENT_COUNT, 0);
        edges(1, 1024);
        rd(OFS_CURRENT_COUNT, 1);
        wr(OFS_MATCH_LIMIT, 32'hff);
        rd(OFS_CURRENT_COUNT, 0);
        $display("divider done");
        wr(OFS_STATUS_CONTROL, 32'h48);
        deep_stop <= 1'b1;
        edges(2, 3);
        rd(OFS_CURRENT_COUNT, 0);
        wr(OFS_STATUS_CONTROL, 32'h08);
        edges(0, 2);
        rd(OFS_CURRENT_COUNT, 2);
        deep_stop <= 1'b0;
        debug_halt <= 1'b1;
        edges(0, 3);
        debug_halt <= 1'b0;
        rd(OFS_CURRENT_COUNT, 2);
        edges(0, 1);
        rd(OFS_CURRENT_COUNT, 3);
        ce <= 1'b0;
        edges(0, 2);
        ce <= 1'b1;
        rd(OFS_CURRENT_COUNT, 3);
        $display("stop and halt done");
        wr(OFS_BUS_GATE, 0);
        rd(OFS_MATCH_LIMIT, 0);
        wr(OFS_MATCH_LIMIT, 32'h55);
        wr(OFS_BUS_GATE, 1);
        rd(OFS_MATCH_LIMIT, 32'hff);
        rd(8'h18, 0);
        rd(OFS_CURRENT_COUNT, 3);
        $display("gate done");
        wr(OFS_IRQ_MASK, 1);
        wr(OFS_MATCH_LIMIT, 0);
        t0 = trig_cnt;
        edges(0, 2);
        rd(OFS_STATUS_CONTROL, 32'h88);
        check(trig_cnt === t0 + 2, "zero limit triggers");
        debug_halt <= 1'b1;
        edges(0, 2);
        debug_halt <= 1'b0;
        irq_is(1'b1);
        check(trig_cnt === t0 + 2, "trigger while halted");
        rd(OFS_IRQ_STATUS, 1);
        rd(OFS_IRQ_STATUS, 0);
        irq_is(1'b0);
        $display("irq status done");
        final_report();
    end
endmodule // testbench
bind periodic_wakeup_counter wakeup_assertions wakeup_assertions_i (
    .core_clk(core_clk), .rst(rst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
    .pslverr(pslverr), .lpo_clk_in(lpo_clk_in), .ext_clk_in(ext_clk_in),
    .int_clk_in(int_clk_in), .debug_halt(debug_halt), .irq(irq),
    .conv_trigger(conv_trigger));
